// ---- logic/xchg_pkg.sv ----
package xchg_pkg;

  // Nibble and instruction word widths
  localparam int NIB_W = 4;
  localparam int INSTR_W = 10;
  localparam int BANK_W = 2;
  localparam int OPC_W = 6;
  localparam int DP_W = BANK_W + 2 * NIB_W;

  // Opcode field position inside the instruction word
  localparam int OPC_LSB = 4;
  localparam int IMM_LSB = 0;

  // Bit of the load value that a carry load takes
  localparam int CARRY_LSB = 0;

  // Upper six bits of the three exchange encodings
  localparam logic [OPC_W-1:0] OPC_SWAP = 6'h2D;
  localparam logic [OPC_W-1:0] OPC_SWAP_DOWN = 6'h2F;
  localparam logic [OPC_W-1:0] OPC_SWAP_UP = 6'h2E;

  // Row values that trigger a skip after the step
  localparam logic [NIB_W-1:0] ROW_WRAP_UP = 4'h0;
  localparam logic [NIB_W-1:0] ROW_WRAP_DOWN = 4'hF;
  localparam logic [NIB_W-1:0] ROW_STEP = 4'h1;

  // Reset values
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
  localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
  localparam logic CARRY_RST = 1'b0;

  // Row movement selected by the decoded instruction
  typedef enum logic [1:0] {
    ROW_HOLD = 2'b00,
    ROW_DOWN = 2'b01,
    ROW_UP = 2'b10
  } row_op_t;

endpackage : xchg_pkg

// ---- logic/xchg_dec_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Instruction word in, decoded exchange controls out
interface xchg_dec_if;
  logic [xchg_pkg::INSTR_W-1:0] instr;
  logic valid;
  logic swap;
  xchg_pkg::row_op_t row_op;
  logic [xchg_pkg::NIB_W-1:0] imm;

  modport core (output instr, output valid, input swap, input row_op, input imm);
  modport dec (input instr, input valid, output swap, output row_op, output imm);
endinterface : xchg_dec_if

`default_nettype wire

// ---- logic/xchg_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

// Pure decode of the three exchange encodings
module xchg_decode (
  xchg_dec_if.dec d // Decode channel
);

  wire logic [xchg_pkg::OPC_W-1:0] opc;
  wire logic hit_plain;
  wire logic hit_down;
  wire logic hit_up;

  // Opcode and immediate fields
  assign opc = d.instr[xchg_pkg::OPC_LSB +: xchg_pkg::OPC_W];
  assign d.imm = d.instr[xchg_pkg::IMM_LSB +: xchg_pkg::NIB_W];

  // Only a word that really executes counts; a skipped word decodes as nothing
  assign hit_plain = d.valid && (opc == xchg_pkg::OPC_SWAP);
  assign hit_down = d.valid && (opc == xchg_pkg::OPC_SWAP_DOWN);
  assign hit_up = d.valid && (opc == xchg_pkg::OPC_SWAP_UP);

  assign d.swap = hit_plain || hit_down || hit_up;
  assign d.row_op = hit_down ? xchg_pkg::ROW_DOWN :
                    hit_up ? xchg_pkg::ROW_UP : xchg_pkg::ROW_HOLD;

endmodule : xchg_decode

`default_nettype wire

// ---- logic/accum_ram_exchange_exec.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - An exchange word swaps the accumulator with the RAM nibble at the data pointer and XORs the column with the 4-bit immediate.
// - The row-up form adds one to the row after the swap and asks to skip the next word when the row becomes 0.
// - The row-up form asks for no skip when the new row is anything other than 0.
// - The row-down form subtracts one from the row and asks to skip the next word only when the row becomes 15.
module accum_ram_exchange_exec (
  input wire logic CLK_SYS_IN, // Instruction clock, 20 MHz
  input wire logic SYS_RST_IN, // Async reset, active high
  input wire logic [xchg_pkg::INSTR_W-1:0] INSTR_IN, // Current instruction word
  input wire logic INSTR_VALID_IN, // Word executes this cycle
  input wire logic [xchg_pkg::NIB_W-1:0] RAM_RDATA_IN, // Nibble at data pointer
  input wire logic LOAD_ACC_IN, // Other group writes accumulator
  input wire logic LOAD_COL_IN, // Other group writes column
  input wire logic LOAD_ROW_IN, // Other group writes row
  input wire logic LOAD_BANK_IN, // Other group writes bank
  input wire logic LOAD_CARRY_IN, // Other group writes carry
  input wire logic [xchg_pkg::NIB_W-1:0] LOAD_DATA_IN, // Value for the loads
  output logic [xchg_pkg::NIB_W-1:0] ACC_OUT, // Accumulator
  output logic [xchg_pkg::NIB_W-1:0] COL_OUT, // Column register
  output logic [xchg_pkg::NIB_W-1:0] ROW_OUT, // Row register
  output logic CARRY_OUT, // Carry flag
  output logic [xchg_pkg::DP_W-1:0] DP_ADDR_OUT, // Data pointer {bank,col,row}
  output logic RAM_WE_OUT, // RAM write strobe
  output logic [xchg_pkg::DP_W-1:0] RAM_WADDR_OUT, // RAM write address
  output logic [xchg_pkg::NIB_W-1:0] RAM_WDATA_OUT, // RAM write data
  output logic SKIP_REQ_OUT // Skip the next word
);

  // Architectural state owned here
  logic [xchg_pkg::NIB_W-1:0] acc_q;
  logic [xchg_pkg::NIB_W-1:0] acc_d;
  logic [xchg_pkg::NIB_W-1:0] col_q;
  logic [xchg_pkg::NIB_W-1:0] col_d;
  logic [xchg_pkg::NIB_W-1:0] row_q;
  logic [xchg_pkg::NIB_W-1:0] row_d;
  logic [xchg_pkg::BANK_W-1:0] bank_q;
  logic [xchg_pkg::BANK_W-1:0] bank_d;
  logic carry_q;
  logic carry_d;

  // Deferred RAM write and skip request
  logic we_q;
  logic [xchg_pkg::DP_W-1:0] waddr_q;
  logic [xchg_pkg::NIB_W-1:0] wdata_q;
  logic skip_q;
  logic skip_d;

  // Decode channel
  xchg_dec_if dec_ch ();

  wire logic [xchg_pkg::NIB_W-1:0] row_stepped;
  wire logic [xchg_pkg::DP_W-1:0] dp_now;
  wire logic row_wrapped;
  wire logic fwd_hit;
  wire logic [xchg_pkg::NIB_W-1:0] ram_nib;

  // Row after the step; plain 4-bit wrap in both directions
  function automatic logic [xchg_pkg::NIB_W-1:0] step_row(
    input logic [xchg_pkg::NIB_W-1:0] row,
    input xchg_pkg::row_op_t op
  );
    logic [xchg_pkg::NIB_W-1:0] r;
    r = row;
    unique case (op)
      xchg_pkg::ROW_UP: r = row + xchg_pkg::ROW_STEP;
      xchg_pkg::ROW_DOWN: r = row - xchg_pkg::ROW_STEP;
      xchg_pkg::ROW_HOLD: r = row;
      default: r = row;
    endcase
    return r;
  endfunction : step_row

  // Wrap test on the stepped row, direction dependent
  function automatic logic wrap_hit(
    input logic [xchg_pkg::NIB_W-1:0] row,
    input xchg_pkg::row_op_t op
  );
    logic hit;
    hit = 1'b0;
    unique case (op)
      xchg_pkg::ROW_UP: hit = (row == xchg_pkg::ROW_WRAP_UP);
      xchg_pkg::ROW_DOWN: hit = (row == xchg_pkg::ROW_WRAP_DOWN);
      xchg_pkg::ROW_HOLD: hit = 1'b0;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : wrap_hit

  // Feed the decoder; instruction comes from core logic on the same clock
  assign dec_ch.instr = INSTR_IN;
  assign dec_ch.valid = INSTR_VALID_IN;

  xchg_decode u_decode (
    .d(dec_ch.dec)
  );

  // Refuse package values that the slicing and wrap logic here cannot serve
  if (xchg_pkg::OPC_LSB + xchg_pkg::OPC_W != xchg_pkg::INSTR_W) begin : bad_opc_field
    $error("Opcode field must end at the top of the instruction word");
  end

  if (xchg_pkg::IMM_LSB + xchg_pkg::NIB_W > xchg_pkg::OPC_LSB) begin : bad_imm_field
    $error("Immediate field must sit below the opcode field");
  end

  if (xchg_pkg::DP_W != xchg_pkg::BANK_W + 2 * xchg_pkg::NIB_W) begin : bad_dp_width
    $error("Data pointer must be exactly bank, column and row");
  end

  if (xchg_pkg::BANK_W > xchg_pkg::NIB_W) begin : bad_bank_width
    $error("Bank is loaded from one nibble and cannot be wider");
  end

  // Decode would give the first match silently if two encodings collided
  if (xchg_pkg::OPC_SWAP == xchg_pkg::OPC_SWAP_DOWN || xchg_pkg::OPC_SWAP == xchg_pkg::OPC_SWAP_UP
      || xchg_pkg::OPC_SWAP_DOWN == xchg_pkg::OPC_SWAP_UP) begin : bad_opc_codes
    $error("The three exchange encodings must be distinct");
  end

  // Skip points must sit one step either side of the wrap
  if (xchg_pkg::ROW_WRAP_DOWN + xchg_pkg::ROW_STEP != xchg_pkg::ROW_WRAP_UP) begin : bad_wrap
    $error("Row wrap points must be one step apart");
  end

  // Address is taken before the column and row move
  assign dp_now = {bank_q, col_q, row_q};
  assign row_stepped = step_row(row_q, dec_ch.row_op);
  assign row_wrapped = wrap_hit(row_stepped, dec_ch.row_op);

  // The write of an exchange lands one edge late, so a second exchange on the same
  // nibble in the next cycle would read stale RAM; take the pending write instead
  assign fwd_hit = we_q && (waddr_q == dp_now);
  assign ram_nib = fwd_hit ? wdata_q : RAM_RDATA_IN;

  // Accumulator: exchange beats a load from another group in the same cycle
  assign acc_d = dec_ch.swap ? ram_nib :
                 LOAD_ACC_IN ? LOAD_DATA_IN : acc_q;

  // Column: XOR with the immediate, whole 0..15 range
  assign col_d = dec_ch.swap ? (col_q ^ dec_ch.imm) :
                 LOAD_COL_IN ? LOAD_DATA_IN : col_q;

  // Row: stepped only by the up and down forms
  assign row_d = dec_ch.swap ? row_stepped :
                 LOAD_ROW_IN ? LOAD_DATA_IN : row_q;

  // Bank is never changed by an exchange
  assign bank_d = (LOAD_BANK_IN && !dec_ch.swap) ?
                  LOAD_DATA_IN[xchg_pkg::BANK_W-1:0] : bank_q;

  // Carry only follows its own load; an exchange leaves it as is
  assign carry_d = (LOAD_CARRY_IN && !dec_ch.swap) ?
                   LOAD_DATA_IN[xchg_pkg::CARRY_LSB] : carry_q;

  // Skip asked for only on a wrap; plain form never skips
  assign skip_d = dec_ch.swap && row_wrapped;

  // Register state; one edge updates accumulator, column and row, the RAM write-back lands one edge later
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      acc_q <= xchg_pkg::NIB_RST;
      col_q <= xchg_pkg::NIB_RST;
      row_q <= xchg_pkg::NIB_RST;
      bank_q <= xchg_pkg::BANK_RST;
      carry_q <= xchg_pkg::CARRY_RST;
    end else begin
      acc_q <= acc_d;
      col_q <= col_d;
      row_q <= row_d;
      bank_q <= bank_d;
      carry_q <= carry_d;
    end
  end

  // Old accumulator goes back to the old address one edge later,
  // so the RAM sees a write port with no combinational path from decode
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= xchg_pkg::NIB_RST;
    end else begin
      we_q <= dec_ch.swap;
      waddr_q <= dp_now;
      wdata_q <= acc_q;
    end
  end

  // Skip pulse lands in the cycle of the following word
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
    end
  end

  // All outputs straight from flops; the pointer is a bare concatenation of three
  // registers, so it carries no logic between flop and pin
  assign ACC_OUT = acc_q;
  assign COL_OUT = col_q;
  assign ROW_OUT = row_q;
  assign CARRY_OUT = carry_q;
  assign DP_ADDR_OUT = dp_now;

  // Write port, one cycle behind the exchange
  assign RAM_WE_OUT = we_q;
  assign RAM_WADDR_OUT = waddr_q;
  assign RAM_WDATA_OUT = wdata_q;

  // Skip request; the sequencer, not this block, must drop the valid of the next word
  assign SKIP_REQ_OUT = skip_q;

endmodule : accum_ram_exchange_exec

`default_nettype wire

// ---- dv/accum_ram_exchange_exec_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module accum_ram_exchange_exec_asserts (
  input wire logic CLK_SYS_IN, // Clock
  input wire logic SYS_RST_IN, // Reset
  input wire logic [9:0] INSTR_IN, // Word
  input wire logic INSTR_VALID_IN, // Word valid
  input wire logic [3:0] RAM_RDATA_IN, // RAM nibble
  input wire logic [3:0] ACC_OUT, // Accumulator
  input wire logic [3:0] COL_OUT, // Column
  input wire logic [3:0] ROW_OUT, // Row
  input wire logic CARRY_OUT, // Carry
  input wire logic [9:0] DP_ADDR_OUT, // Pointer
  input wire logic RAM_WE_OUT, // Write strobe
  input wire logic [9:0] RAM_WADDR_OUT, // Write address
  input wire logic [3:0] RAM_WDATA_OUT, // Write data
  input wire logic SKIP_REQ_OUT // Skip
);
  // Only valid words with an exchange opcode count
  wire logic [5:0] opc = INSTR_IN[9:4];
  wire logic xe = INSTR_VALID_IN && (opc inside {6'h2D, 6'h2E, 6'h2F});
  // Nibble at the pointer, counting a write-back that has not reached the RAM yet
  wire logic [3:0] ram_seen = (RAM_WE_OUT && (RAM_WADDR_OUT == DP_ADDR_OUT)) ?
    RAM_WDATA_OUT : RAM_RDATA_IN;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  chk_acc_swap: assert property (xe |=> ACC_OUT == $past(ram_seen))
    else $error("acc not swapped");
  chk_col_xor: assert property (
    xe |=> COL_OUT == ($past(COL_OUT) ^ $past(INSTR_IN[3:0])))
    else $error("column xor wrong");
  chk_ram_wback: assert property (
    xe |=> RAM_WE_OUT && RAM_WDATA_OUT == $past(ACC_OUT)
      && RAM_WADDR_OUT == $past(DP_ADDR_OUT))
    else $error("write back wrong");
  chk_row_up: assert property (
    xe && opc == 6'h2E |=> ROW_OUT == $past(ROW_OUT) + 4'h1
      && SKIP_REQ_OUT == (ROW_OUT == 4'h0))
    else $error("row up or skip wrong");
  chk_row_down: assert property (
    xe && opc == 6'h2F |=> ROW_OUT == $past(ROW_OUT) - 4'h1
      && SKIP_REQ_OUT == (ROW_OUT == 4'hF))
    else $error("row down or skip wrong");
  chk_plain_row: assert property (
    xe && opc == 6'h2D |=> $stable(ROW_OUT) && !SKIP_REQ_OUT)
    else $error("plain swap moved row");
  chk_carry_kept: assert property (xe |=> $stable(CARRY_OUT))
    else $error("carry changed");
  chk_pulse_one: assert property (!xe |=> !SKIP_REQ_OUT && !RAM_WE_OUT)
    else $error("pulse without exchange");
  // Main scenarios reached
  cov_up_wrap: cover property (xe && opc == 6'h2E ##1 SKIP_REQ_OUT);
  cov_down_wrap: cover property (xe && opc == 6'h2F ##1 SKIP_REQ_OUT);
  cov_plain: cover property (xe && opc == 6'h2D);
  cov_back_to_back: cover property (xe ##1 xe);
endmodule : accum_ram_exchange_exec_asserts
bind accum_ram_exchange_exec accum_ram_exchange_exec_asserts accum_ram_exchange_exec_asserts_inst (
  .CLK_SYS_IN, .SYS_RST_IN, .INSTR_IN, .INSTR_VALID_IN, .RAM_RDATA_IN, .ACC_OUT,
  .COL_OUT, .ROW_OUT, .CARRY_OUT, .DP_ADDR_OUT, .RAM_WE_OUT, .RAM_WADDR_OUT,
  .RAM_WDATA_OUT, .SKIP_REQ_OUT);
`default_nettype wire

// ---- dv/accum_ram_exchange_exec_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module accum_ram_exchange_exec_tb_top;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, la = 1'b0, lc = 1'b0, lr = 1'b0, lb = 1'b0, ly = 1'b0;
  logic [9:0] instr = 10'h000;
  logic [3:0] ram = 4'h0, ldat = 4'h0, acc, col, row, wdat;
  logic cy, we, skip;
  logic [9:0] dp, wadr;
  int miscompares = 0, check_count = 0, cycles = 0;
  always #25 clk = ~clk;
  accum_ram_exchange_exec accum_ram_exchange_exec_inst (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
    .INSTR_IN(instr), .INSTR_VALID_IN(vld), .RAM_RDATA_IN(ram), .LOAD_ACC_IN(la),
    .LOAD_COL_IN(lc), .LOAD_ROW_IN(lr), .LOAD_BANK_IN(lb), .LOAD_CARRY_IN(ly),
    .LOAD_DATA_IN(ldat), .ACC_OUT(acc), .COL_OUT(col), .ROW_OUT(row), .CARRY_OUT(cy),
    .DP_ADDR_OUT(dp), .RAM_WE_OUT(we), .RAM_WADDR_OUT(wadr), .RAM_WDATA_OUT(wdat),
    .SKIP_REQ_OUT(skip));
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Hang guard, the whole run needs well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  // One load of the other groups, order {acc,col,row,bank,carry}
  task automatic load(input logic [4:0] en, input logic [3:0] v);
    @(posedge clk);
    {la, lc, lr, lb, ly} <= en;
    ldat <= v;
    @(posedge clk);
    {la, lc, lr, lb, ly} <= 5'h00;
  endtask : load
  // One word in, outputs judged in the following cycle; l is {acc,col,row,bank,carry}
  task automatic exec(input logic [9:0] w, input logic [3:0] r, input logic v,
                      input logic [4:0] l);
    @(posedge clk);
    instr <= w;
    ram <= r;
    vld <= v;
    {la, lc, lr, lb, ly} <= l;
    ldat <= 4'hC;
    @(posedge clk);
    vld <= 1'b0;
    {la, lc, lr, lb, ly} <= 5'h00;
    @(negedge clk);
  endtask : exec
  task automatic look(input logic [3:0] a, c, y, input logic s, e, input logic [3:0] d);
    chk("acc", 10'(a), 10'(acc));
    chk("col", 10'(c), 10'(col));
    chk("row", 10'(y), 10'(row));
    chk("skip", 10'(s), 10'(skip));
    chk("we", 10'(e), 10'(we));
    chk("wdata", 10'(d), 10'(wdat));
    chk("carry", 10'h001, 10'(cy));
  endtask : look
  task automatic scn_up_wrap();
    load(5'h10, 4'hA);
    load(5'h08, 4'h5);
    load(5'h04, 4'hF);
    load(5'h02, 4'h2);
    load(5'h01, 4'h1);
    exec(10'h2E3, 4'h7, 1'b1, 5'h00);
    look(4'h7, 4'h6, 4'h0, 1'b1, 1'b1, 4'hA);
    chk("waddr", 10'h25F, wadr);
  endtask : scn_up_wrap
  task automatic scn_up_plain();
    exec(10'h2E0, 4'h3, 1'b1, 5'h00);
    look(4'h3, 4'h6, 4'h1, 1'b0, 1'b1, 4'h7);
  endtask : scn_up_plain
  task automatic scn_down();
    exec(10'h2F1, 4'h4, 1'b1, 5'h00);
    look(4'h4, 4'h7, 4'h0, 1'b0, 1'b1, 4'h3);
    exec(10'h2FF, 4'h5, 1'b1, 5'h00);
    look(4'h5, 4'h8, 4'hF, 1'b1, 1'b1, 4'h4);
    chk("waddr", 10'h270, wadr);
  endtask : scn_down
  // Plain swap wins over every load; idle and foreign words do nothing
  task automatic scn_plain_idle();
    exec(10'h2D3, 4'h6, 1'b1, 5'h1F);
    look(4'h6, 4'hB, 4'hF, 1'b0, 1'b1, 4'h5);
    chk("dp", 10'h2BF, dp);
    exec(10'h2E0, 4'h1, 1'b0, 5'h00);
    look(4'h6, 4'hB, 4'hF, 1'b0, 1'b0, 4'h6);
    exec(10'h2C0, 4'h1, 1'b1, 5'h00);
    look(4'h6, 4'hB, 4'hF, 1'b0, 1'b0, 4'h6);
  endtask : scn_plain_idle
  // Two swaps back to back on one nibble; RAM still stale at the second edge
  task automatic scn_back_to_back();
    @(posedge clk);
    instr <= 10'h2D0;
    ram <= 4'h2;
    vld <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    vld <= 1'b0;
    @(negedge clk);
    look(4'h6, 4'hB, 4'hF, 1'b0, 1'b1, 4'h2);
    chk("waddr", 10'h2BF, wadr);
  endtask : scn_back_to_back
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("acc rst", 10'h000, 10'(acc));
    chk("skip rst", 10'h000, 10'(skip));
    scn_up_wrap();
    scn_up_plain();
    scn_down();
    scn_plain_idle();
    scn_back_to_back();
    print_verdict();
  end
endmodule : accum_ram_exchange_exec_tb_top
`default_nettype wire
